//--- rtl/esw_error_state_word.sv
/*
  builds the processor state parameter word on a machine check or init
  event, applies the consistency ties, and publishes it on state_param_reg
  at handler exit and over apb. assumes single-cycle event pulses on pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module esw_error_state_word
  import esw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mc_event,
  input wire logic init_event,
  input wire esw_report_s report,
  input wire logic handler_exit,
  output logic [63:0] state_param_reg,
  output logic word_valid
);

  esw_state_e state_reg;
  logic cause_init_reg;
  logic [63:0] word_reg;
  logic save_area_registered;
  logic init_rz_val;
  logic init_ra_val;
  logic [63:0] word_next;
  logic apb_wr;
  logic apb_rd;

  // consistency ties and field placement of the word
  function automatic logic [63:0] build_word(input esw_report_s r, input logic is_init,
                                             input logic save_ok, input logic rz_i,
                                             input logic ra_i);
    logic iso;
    logic dmg;
    logic res;
    logic syn;
    logic [63:0] w;
    begin
      w = ESW_RESET;
      if (is_init)
      begin
        iso = 1'b1;
        dmg = 1'b0;
        res = 1'b1;
        syn = 1'b0;
        w[B_RZ_OK] = rz_i;
        w[B_RA_TRY] = ra_i;
      end
      else
      begin
        res = r.resumable_flag & r.state_all_valid;
        iso = r.error_isolated | res;
        dmg = (r.uncontained_damage | ~iso) & ~res;
        res = res & ~dmg;
        syn = r.storage_in_step & ~dmg & iso;
        w[B_RZ_OK] = r.rendezvous_ok;
        w[B_RA_TRY] = r.rendezvous_tried;
        w[B_DIST] = r.distinct_errors_flag;
        w[B_HWD] = r.hw_degraded;
        w[B_TRAP] = r.trap_dropped;
        w[B_MORE] = r.extra_detail_avail;
      end
      w[B_SAVE] = save_ok;
      w[B_SYNC] = syn;
      w[B_RES] = res;
      w[B_ISO] = iso;
      w[B_DMG] = dmg;
      w[B_CAUSE] = is_init;
      build_word = w;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // capture
  assign word_next = build_word(report, init_event, save_area_registered, init_rz_val,
                                init_ra_val);

  // event sequencing: init wins when both arrive together
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ESW_IDLE;
      word_reg <= ESW_RESET;
      cause_init_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ESW_IDLE, ESW_HOLD:
        begin
          if (mc_event | init_event)
          begin
            word_reg <= word_next;
            cause_init_reg <= init_event;
            state_reg <= ESW_BUILD;
          end
        end
        ESW_BUILD:
        begin
          if (handler_exit)
          begin
            state_reg <= ESW_HOLD;
          end
        end
        default:
        begin
          state_reg <= ESW_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_param_reg <= ESW_RESET;
      word_valid <= 1'b0;
    end
    else if (state_reg == ESW_BUILD && handler_exit)
    begin
      state_param_reg <= word_reg;
      word_valid <= 1'b1;
    end
    else if (mc_event | init_event)
    begin
      word_valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // control: bit0 save area registered, bits1-2 init-time rendezvous values
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      save_area_registered <= 1'b0;
      init_rz_val <= 1'b0;
      init_ra_val <= 1'b0;
    end
    else if (apb_wr && paddr == OFF_CTRL)
    begin
      save_area_registered <= pwdata[0];
      init_rz_val <= pwdata[1];
      init_ra_val <= pwdata[2];
    end
  end

  // unused and reserved bits read zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= ZERO32;
    end
    else if (apb_rd && !penable)
    begin
      if (paddr == OFF_WORD_LO)
        prdata <= state_param_reg[31:0];
      else if (paddr == OFF_WORD_HI)
        prdata <= state_param_reg[63:32];
      else if (paddr == OFF_STATUS)
        prdata <= {28'h0000000, cause_init_reg, word_valid, state_reg};
      else if (paddr == OFF_CTRL)
        prdata <= {29'h00000000, init_ra_val, init_rz_val, save_area_registered};
      else
        prdata <= ZERO32;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // captured continuable ties
  chk_res_ties: assert property (@(posedge pclk) disable iff (!presetn)
    word_reg[B_RES] |-> (word_reg[B_ISO] && !word_reg[B_DMG]))
    else $error("continuable without isolation");
  // captured isolation ties, only once a word was taken
  chk_iso_ties: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg != ESW_IDLE && !word_reg[B_ISO]) |->
      (word_reg[B_DMG] && !word_reg[B_RES] && !word_reg[B_SYNC]))
    else $error("not isolated yet no damage");
  chk_dmg_ties: assert property (@(posedge pclk) disable iff (!presetn)
    word_reg[B_DMG] |-> !(word_reg[B_RES] || word_reg[B_SYNC]))
    else $error("damage with continuable or sync");
  chk_init_word: assert property (@(posedge pclk) disable iff (!presetn)
    (init_event && state_reg != ESW_BUILD) |=> (word_reg[B_RES] && word_reg[B_ISO] &&
      word_reg[B_CAUSE] && word_reg[12:9] == 4'h0 && !word_reg[B_DIST] && !word_reg[B_SYNC]))
    else $error("init word fields wrong");
  chk_mc_cause: assert property (@(posedge pclk) disable iff (!presetn)
    (mc_event && !init_event && state_reg != ESW_BUILD) |=> !word_reg[B_CAUSE])
    else $error("machine check cause wrong");
  chk_res_valid: assert property (@(posedge pclk) disable iff (!presetn)
    (mc_event && !init_event && state_reg != ESW_BUILD && !report.state_all_valid)
      |=> !word_reg[B_RES])
    else $error("continuable without valid state");
  chk_publish: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ESW_BUILD && handler_exit) |=>
      (word_valid && state_param_reg == $past(word_reg)))
    else $error("word not published at exit");
  chk_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    state_param_reg[1:0] == 2'b00 && state_param_reg[15:13] == 3'b000 &&
      state_param_reg[63:17] == 47'h0)
    else $error("reserved bits nonzero");
  chk_save_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (mc_event && state_reg != ESW_BUILD) |=> word_reg[B_SAVE] == $past(save_area_registered))
    else $error("save area bit wrong");
  chk_pub_res: assert property (@(posedge pclk) disable iff (!presetn)
    state_param_reg[B_RES] |-> (state_param_reg[B_ISO] && !state_param_reg[B_DMG]))
    else $error("published continuable without isolation");
  chk_pub_iso: assert property (@(posedge pclk) disable iff (!presetn)
    (word_valid && !state_param_reg[B_ISO]) |->
      (state_param_reg[B_DMG] && !state_param_reg[B_RES] && !state_param_reg[B_SYNC]))
    else $error("published word not isolated yet no damage");
  chk_pub_dmg: assert property (@(posedge pclk) disable iff (!presetn)
    state_param_reg[B_DMG] |-> !(state_param_reg[B_RES] || state_param_reg[B_SYNC]))
    else $error("published damage with continuable or sync");
  chk_init_rdv: assert property (@(posedge pclk) disable iff (!presetn)
    (init_event && state_reg != ESW_BUILD) |=>
      (word_reg[B_RZ_OK] == $past(init_rz_val) && word_reg[B_RA_TRY] == $past(init_ra_val)))
    else $error("init rendezvous bits wrong");
  chk_mc_rdv: assert property (@(posedge pclk) disable iff (!presetn)
    (mc_event && !init_event && state_reg != ESW_BUILD) |=>
      (word_reg[B_RA_TRY] == $past(report.rendezvous_tried) &&
        word_reg[B_RZ_OK] == $past(report.rendezvous_ok)))
    else $error("check rendezvous bits wrong");
  chk_mc_fields: assert property (@(posedge pclk) disable iff (!presetn)
    (mc_event && !init_event && state_reg != ESW_BUILD) |=>
      (word_reg[B_HWD] == $past(report.hw_degraded) &&
        word_reg[B_TRAP] == $past(report.trap_dropped) &&
        word_reg[B_MORE] == $past(report.extra_detail_avail) &&
        word_reg[B_DIST] == $past(report.distinct_errors_flag)))
    else $error("check report fields wrong");
  chk_iso_report: assert property (@(posedge pclk) disable iff (!presetn)
    (mc_event && !init_event && state_reg != ESW_BUILD && report.error_isolated) |=>
      word_reg[B_ISO])
    else $error("isolated report lost");
  chk_sync_need: assert property (@(posedge pclk) disable iff (!presetn)
    (mc_event && !init_event && state_reg != ESW_BUILD && !report.storage_in_step) |=>
      !word_reg[B_SYNC])
    else $error("sync set without clean storage");
  chk_dmg_report: assert property (@(posedge pclk) disable iff (!presetn)
    (mc_event && !init_event && state_reg != ESW_BUILD && report.uncontained_damage &&
      !report.resumable_flag) |=> word_reg[B_DMG])
    else $error("storage damage lost");
  chk_build_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ESW_BUILD && !handler_exit) |=>
      (state_reg == ESW_BUILD && $stable(word_reg)))
    else $error("captured word changed inside handler");
  chk_word_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(state_reg == ESW_BUILD && handler_exit) |=> $stable(state_param_reg))
    else $error("published word changed outside exit");
  chk_valid_drop: assert property (@(posedge pclk) disable iff (!presetn)
    ((mc_event || init_event) && !(state_reg == ESW_BUILD && handler_exit)) |=> !word_valid)
    else $error("fresh flag kept after event");

endmodule // esw_error_state_word
`default_nettype wire

//--- rtl/esw_pkg.sv
/*
  package for the error state word block: field positions, register
  offsets, state encodings and the packed carrier of the raw error report.
  assumes an apb master on pclk and a machine check / init event source
  on the same clock.
*/
package esw_pkg;
  localparam int ESW_W = 64;
  localparam int B_RZ_OK = 2;
  localparam int B_RA_TRY = 3;
  localparam int B_DIST = 4;
  localparam int B_SAVE = 5;
  localparam int B_SYNC = 6;
  localparam int B_RES = 7;
  localparam int B_ISO = 8;
  localparam int B_DMG = 9;
  localparam int B_HWD = 10;
  localparam int B_TRAP = 11;
  localparam int B_MORE = 12;
  localparam int B_CAUSE = 16;
  // apb byte offsets
  localparam logic [11:0] OFF_WORD_LO = 12'h000;
  localparam logic [11:0] OFF_WORD_HI = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_CTRL = 12'h00C;
  localparam logic [63:0] ESW_RESET = 64'h0000_0000_0000_0000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  // raw error report from the detection logic
  typedef struct packed {
    logic rendezvous_ok;
    logic rendezvous_tried;
    logic distinct_errors_flag;
    logic storage_in_step;
    logic resumable_flag;
    logic error_isolated;
    logic uncontained_damage;
    logic hw_degraded;
    logic trap_dropped;
    logic extra_detail_avail;
    logic state_all_valid;
  } esw_report_s;

  typedef enum logic [1:0] {
    ESW_IDLE = 2'b00,
    ESW_BUILD = 2'b01,
    ESW_HOLD = 2'b10
  } esw_state_e;
endpackage : esw_pkg

//--- test/esw_testbench.sv
/*
  self-checking bench for the error state word block: init and machine
  check words, consistency ties, apb readback and unmapped reads.
  assumes the design answers apb with pready and publishes on handler_exit.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import esw_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, mc_event, init_event, handler_exit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, word_valid;
  logic [10:0] rep_bits;
  logic [63:0] state_param_reg;
  int errors, cmp_count;
  logic [10:0] vec [8] = '{11'h7FF, 11'h040, 11'h080, 11'h0A0, 11'h0B0, 11'h061,
                           11'h00E, 11'h600};
  ////////////////////////////////////////////////////////////////////////
  esw_error_state_word i_esw_error_state_word (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mc_event(mc_event), .init_event(init_event), .report(esw_report_s'(rep_bits)),
    .handler_exit(handler_exit), .state_param_reg(state_param_reg),
    .word_valid(word_valid));
  // clock and watchdog
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    #200000;
    errors = errors + 1;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    check({63'h0, pslverr}, 64'h0); // bus never errors
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected machine check word from the report and save-area flag
  function automatic logic [63:0] exp_mc(input logic [10:0] r, input logic sv);
    logic res, iso, dmg;
    exp_mc = 64'h0;
    res = r[6] & r[0];
    iso = r[5] | res;
    dmg = (r[4] | ~iso) & ~res;
    exp_mc[B_RZ_OK] = r[10];
    exp_mc[B_RA_TRY] = r[9];
    exp_mc[B_DIST] = r[8];
    exp_mc[B_SAVE] = sv;
    exp_mc[B_SYNC] = r[7] & ~dmg & iso;
    exp_mc[B_RES] = res;
    exp_mc[B_ISO] = iso;
    exp_mc[B_DMG] = dmg;
    exp_mc[B_HWD] = r[3];
    exp_mc[B_TRAP] = r[2];
    exp_mc[B_MORE] = r[1];
  endfunction
  // raise one event, exit the handler and compare the published word
  task automatic run_event(input logic ini, input logic [10:0] r, input logic [63:0] exp);
    @(posedge pclk);
    mc_event <= ~ini;
    init_event <= ini;
    rep_bits <= r;
    @(posedge pclk);
    mc_event <= 1'b0;
    init_event <= 1'b0;
    @(posedge pclk);
    handler_exit <= 1'b1;
    @(posedge pclk);
    handler_exit <= 1'b0;
    while (word_valid !== 1'b1)
    begin
      @(posedge pclk);
    end
    #1;
    check(state_param_reg, exp); // published word
    apb(1'b0, OFF_WORD_LO, 32'h0);
    check({32'h0, rd}, {32'h0, exp[31:0]}); // low half readback
    apb(1'b0, OFF_WORD_HI, 32'h0);
    check({32'h0, rd}, {32'h0, exp[63:32]}); // high half readback
    apb(1'b0, OFF_STATUS, 32'h0);
    check({32'h0, rd}, {60'h0, ini, 3'h6}); // cause, fresh, hold in status
  endtask
  ////////////////////////////////////////////////////////////////////////
  // init word carries fixed values and control flags
  task automatic init_case();
    apb(1'b1, OFF_CTRL, 32'h0000_0007);
    apb(1'b0, OFF_CTRL, 32'h0);
    check({32'h0, rd}, 64'h0000_0000_0000_0007); // control readback
    run_event(1'b1, 11'h7FF, 64'h0000_0000_0001_01AC); // init word
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    run_event(1'b1, 11'h000, 64'h0000_0000_0001_0180); // zero on init
  endtask
  // machine check words and their consistency ties
  task automatic mc_case();
    logic [63:0] w;
    w = exp_mc(vec[7], 1'b1);
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    foreach (vec[i])
      run_event(1'b0, vec[i], exp_mc(vec[i], 1'b1)); // ties
    apb(1'b1, OFF_WORD_LO, 32'hFFFF_FFFF);
    apb(1'b0, OFF_WORD_LO, 32'h0);
    check({32'h0, rd}, {32'h0, w[31:0]}); // read-only word
    apb(1'b0, 12'h010, 32'h0);
    check({32'h0, rd}, 64'h0); // unmapped reads zero
  endtask
  ////////////////////////////////////////////////////////////////////////
  // verdict
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    errors = 0;
    cmp_count = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, mc_event, init_event, handler_exit} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    rep_bits = 11'h000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    init_case();
    mc_case();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
